/* File: hdl/sdc_buf2.sv */
// Two-entry valid/ready buffer on the read data path.
`timescale 1ns/1ps
`default_nettype none
module sdc_buf2
	import sdc_pkg::*;
#(
	parameter int W = RDW_W
) (
	// Clock and reset.
	input  wire logic         sys_clk_in,
	input  wire logic         rst_b_in,
	// Filling side.
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	// Draining side.
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);

	logic [W-1:0] mem_q [2];
	logic         wr_ptr_q;
	logic         rd_ptr_q;
	logic [1:0]   cnt_q;
	wire          push = in_valid_in && in_ready_out;
	wire          pop  = out_valid_out && out_ready_in;

	// Full and empty follow the occupancy count.
	assign in_ready_out  = cnt_q != 2'h2;
	assign out_valid_out = cnt_q != 2'h0;
	assign out_data_out  = mem_q[rd_ptr_q];

	// Pointers and occupancy.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			cnt_q    <= 2'h0;
		end else begin
			if (push)
				wr_ptr_q <= ~wr_ptr_q;
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
		end
	end

	// Storage holds no control state, so it needs no reset.
	always_ff @(posedge sys_clk_in) begin
		if (push)
			mem_q[wr_ptr_q] <= in_data_in;
	end

endmodule : sdc_buf2
`default_nettype wire

/* File: hdl/sdc_core.sv */
// Device-side command decoder, bank state, burst engine and storage array.
`timescale 1ns/1ps
`default_nettype none
module sdc_core
	import sdc_pkg::*;
(
	// Clock and reset.
	input  wire logic              sys_clk_in,
	input  wire logic              rst_b_in,
	// Command pins.
	input  wire logic              cke_in,
	input  wire logic              cs_b_in,
	input  wire logic              ras_b_in,
	input  wire logic              cas_b_in,
	input  wire logic              we_b_in,
	input  wire logic              bank_sel_hi_in,
	input  wire logic              bank_sel_lo_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DQM_W-1:0]  dqm_in,
	// Data pins.
	input  wire logic [DQ_W-1:0]   dq_in,
	output logic [DQ_W-1:0]        dq_out,
	output logic                   dq_oe_out,
	// Status.
	output logic [BANK_N-1:0]      bank_open_out,
	output logic [1:0]             pwr_state_out,
	output logic [ADDR_W-1:0]      refresh_row_out
);

	////////////////////////////////////////////////////////////////////////
	// State.

	logic [DQ_W-1:0]   mem_q [2**MEM_W];
	logic              cke_q;
	sdc_pwr_t          pwr_q;
	logic [ADDR_W-1:0] mode_q;
	logic [BANK_N-1:0] open_q;
	logic [ADDR_W-1:0] row_q [BANK_N];
	logic              bact_q;
	logic              bwr_q;
	logic              bap_q;
	logic [BANK_W-1:0] bbank_q;
	logic [COL_W-1:0]  bstart_q;
	logic [COL_W-1:0]  bcnt_q;
	logic [1:0]        wait_q;
	logic [DQ_W-1:0]   dq_q;
	logic              oe_q;
	logic [ADDR_W-1:0] ref_row_q;
	logic [10:0]       sref_tmr_q;

	////////////////////////////////////////////////////////////////////////
	// Command decode.

	sdc_pins_t         pins;
	sdc_cmd_t          cmd;
	wire               run = cke_q && (pwr_q == PWR_RUN);
	wire [2:0]         bl_mode = mode_q[MODE_BL_LSB +: 3];
	wire               ilv = mode_q[MODE_BT_BIT];
	wire [2:0]         cl = mode_q[MODE_CL_LSB +: 3];
	wire               wr_single = mode_q[MODE_WB_BIT];

	// Inputs grouped as sampled on this rising edge.
	assign pins = '{cs_b: cs_b_in, ras_b: ras_b_in, cas_b: cas_b_in,
		we_b: we_b_in, bank: {bank_sel_hi_in, bank_sel_lo_in},
		addr: addr_in, dqm: dqm_in};
	// Chip select high decodes as no operation.
	assign cmd = pins.cs_b ? CMD_NOP
		: sdc_cmd_t'({1'b0, pins.ras_b, pins.cas_b, pins.we_b});

	wire               idle = (open_q == '0) && !bact_q;
	wire               c_act = run && (cmd == CMD_ACT);
	wire               c_pre = run && (cmd == CMD_PRE);
	wire               c_rd  = run && (cmd == CMD_RD)
		&& open_q[pins.bank];
	wire               c_wr  = run && (cmd == CMD_WR)
		&& open_q[pins.bank];
	wire               c_bst = run && (cmd == CMD_BST);
	wire               c_mrs = run && (cmd == CMD_MRS) && idle;
	wire               c_ref = run && (cmd == CMD_REF) && idle && cke_in;
	wire               c_sre = run && (cmd == CMD_REF) && idle && !cke_in;
	wire               pre_all = pins.addr[AP_BIT];
	wire               pre_hit = c_pre && (pre_all || pins.bank == bbank_q);
	wire [COL_W-1:0]   col_in = pins.addr[COL_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Burst engine.

	wire [2:0]         bl_eff = (bwr_q && wr_single) ? BL_1 : bl_mode;
	wire [COL_W-1:0]   bcol = sdc_burst_col(bstart_q, bcnt_q, bl_eff, ilv);
	wire               blast = sdc_burst_last(bcnt_q, bl_eff);
	wire [MEM_W-1:0]   baddr = {bbank_q, row_q[bbank_q], bcol};
	wire               buf_in_ready;
	wire               buf_out_valid;
	sdc_rd_word_t      buf_out;
	wire               rd_step = run && bact_q && !bwr_q
		&& (wait_q == '0) && buf_in_ready;
	wire               wr_step = run && bact_q && bwr_q;
	wire               step = rd_step || wr_step;
	wire               bend = step && blast;
	wire               bkill = c_bst || pre_hit || c_rd || c_wr;
	wire               bfirst_last = sdc_burst_last(8'h00,
		(c_wr && wr_single) ? BL_1 : bl_mode);
	sdc_rd_word_t      rd_word;

	assign rd_word = '{data: mem_q[baddr], mask: pins.dqm};

	// Read words queue here so a suspended output loses none.
	sdc_buf2 #(
		.W(RDW_W)
	) u_rd_buf (
		.sys_clk_in   (sys_clk_in),
		.rst_b_in     (rst_b_in),
		.in_valid_in  (rd_step),
		.in_ready_out (buf_in_ready),
		.in_data_in   (rd_word),
		.out_valid_out(buf_out_valid),
		.out_ready_in (run),
		.out_data_out (buf_out)
	);

	// Burst control: start, step, stop and auto precharge request.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bact_q   <= 1'b0;
			bwr_q    <= 1'b0;
			bap_q    <= 1'b0;
			bbank_q  <= '0;
			bstart_q <= '0;
			bcnt_q   <= '0;
			wait_q   <= '0;
		end else if (c_rd || c_wr) begin
			bact_q   <= !(c_wr && bfirst_last);
			bwr_q    <= c_wr;
			bap_q    <= pins.addr[AP_BIT];
			bbank_q  <= pins.bank;
			bstart_q <= col_in;
			bcnt_q   <= c_wr ? 8'h01 : 8'h00;
			wait_q   <= (cl == CL_3) ? WAIT_CL3 : WAIT_CL2;
		end else if (c_bst || pre_hit) begin
			bact_q <= 1'b0;
		end else if (run && bact_q && !bwr_q && wait_q != '0) begin
			wait_q <= 2'(wait_q - 2'h1);
		end else if (step) begin
			bcnt_q <= 8'(bcnt_q + 8'h01);
			if (blast)
				bact_q <= 1'b0;
		end
	end

	// Array writes: first word with the command, then each burst beat.
	always_ff @(posedge sys_clk_in) begin
		if (c_wr) begin
			for (int b = 0; b < DQM_W; b++)
				if (!pins.dqm[b])
					mem_q[{pins.bank, row_q[pins.bank], col_in}][b*8 +: 8]
						<= dq_in[b*8 +: 8];
		end else if (wr_step && !bkill) begin
			for (int b = 0; b < DQM_W; b++)
				if (!pins.dqm[b])
					mem_q[baddr][b*8 +: 8] <= dq_in[b*8 +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bank state and mode register.

	// A single-beat write takes its own auto precharge request at once.
	wire               ap_single = c_wr && bfirst_last && pins.addr[AP_BIT];
	wire               ap_close = (bap_q && bend && !bkill) || ap_single;
	wire [BANK_W-1:0]  ap_bank = ap_single ? pins.bank : bbank_q;

	// Rows open on activate and close on precharge or auto precharge.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			open_q <= '0;
			for (int i = 0; i < BANK_N; i++)
				row_q[i] <= '0;
		end else begin
			if (c_act) begin
				open_q[pins.bank] <= 1'b1;
				row_q[pins.bank]  <= pins.addr;
			end
			if (c_pre && pre_all)
				open_q <= '0;
			else if (c_pre)
				open_q[pins.bank] <= 1'b0;
			if (ap_close)
				open_q[ap_bank] <= 1'b0;
		end
	end

	// Mode settings load from the address lines.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			mode_q <= MODE_RESET;
		else if (c_mrs)
			mode_q <= pins.addr;
	end

	////////////////////////////////////////////////////////////////////////
	// Clock enable, power states and refresh.

	// Clock enable is sampled each edge; its low gates the next cycle.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			cke_q <= 1'b1;
		else
			cke_q <= cke_in;
	end

	// Power state; only clock enable is looked at while powered down.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pwr_q <= PWR_RUN;
		end else begin
			case (pwr_q)
				PWR_RUN: begin
					if (c_sre)
						pwr_q <= PWR_SELF;
					else if (cke_q && !cke_in && idle)
						pwr_q <= PWR_DOWN;
					else if (cke_q && !cke_in)
						pwr_q <= PWR_SUSP;
				end
				PWR_SUSP, PWR_DOWN, PWR_SELF: begin
					if (cke_in)
						pwr_q <= PWR_RUN;
				end
				default: pwr_q <= PWR_RUN;
			endcase
		end
	end

	// Refresh row counter and self refresh interval timer.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ref_row_q  <= '0;
			sref_tmr_q <= '0;
		end else if (c_ref) begin
			ref_row_q <= 12'(ref_row_q + 12'h001);
		end else if (pwr_q == PWR_SELF) begin
			if (sref_tmr_q == SELF_REF_CYC - 11'h001) begin
				sref_tmr_q <= '0;
				ref_row_q  <= 12'(ref_row_q + 12'h001);
			end else begin
				sref_tmr_q <= 11'(sref_tmr_q + 11'h001);
			end
		end else begin
			sref_tmr_q <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output stage.

	// Data and enable hold while the clock is suspended.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dq_q <= '0;
			oe_q <= 1'b0;
		end else if (run) begin
			dq_q <= buf_out.data;
			oe_q <= buf_out_valid && (buf_out.mask == '0);
		end else if (pwr_q != PWR_RUN && pwr_q != PWR_SUSP) begin
			oe_q <= 1'b0;
		end
	end

	assign dq_out          = dq_q;
	assign dq_oe_out       = oe_q;
	assign bank_open_out   = open_q;
	assign pwr_state_out   = pwr_q;
	assign refresh_row_out = ref_row_q;

endmodule : sdc_core
`default_nettype wire

/* File: hdl/sdc_pkg.sv */
// Package of constants, types and helper functions for the SDRAM command interface.
package sdc_pkg;

	// Geometry of the array and of the pins.
	localparam int ADDR_W = 12;
	localparam int COL_W  = 8;
	localparam int DQ_W   = 16;
	localparam int DQM_W  = 2;
	localparam int BANK_N = 4;
	localparam int BANK_W = 2;
	localparam int MEM_W  = BANK_W + ADDR_W + COL_W;

	// Address fields of the column and precharge commands.
	localparam int AP_BIT = 10;

	// Mode register field layout and reset value.
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_BT_BIT = 3;
	localparam int MODE_CL_LSB = 4;
	localparam int MODE_WB_BIT = 9;
	localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;

	// Burst length codes.
	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_FULL = 3'h7;

	// Read latency codes and the pre-read wait each one needs.
	localparam logic [2:0] CL_3    = 3'h3;
	localparam logic [1:0] WAIT_CL2 = 2'h0;
	localparam logic [1:0] WAIT_CL3 = 2'h1;

	// Refresh timing: 4096 rows in every 64 ms at a 100 MHz clock.
	localparam int REF_WINDOW_MS = 64;
	localparam int REF_ROWS      = 4096;
	localparam int CLK_KHZ       = 100000;
	localparam int SELF_REF_INT  = (REF_WINDOW_MS * CLK_KHZ) / REF_ROWS;
	localparam logic [10:0] SELF_REF_CYC = 11'(SELF_REF_INT);

	// Command codes formed as {cs_b, ras_b, cas_b, we_b}.
	typedef enum logic [3:0] {
		CMD_MRS = 4'h0,
		CMD_REF = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WR  = 4'h4,
		CMD_RD  = 4'h5,
		CMD_BST = 4'h6,
		CMD_NOP = 4'h7
	} sdc_cmd_t;

	// Power state, Gray coded along run, suspend, power down, self refresh.
	typedef enum logic [1:0] {
		PWR_RUN  = 2'h0,
		PWR_SUSP = 2'h1,
		PWR_DOWN = 2'h3,
		PWR_SELF = 2'h2
	} sdc_pwr_t;

	// Command pins sampled together on one clock edge.
	typedef struct packed {
		logic              cs_b;
		logic              ras_b;
		logic              cas_b;
		logic              we_b;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic [DQM_W-1:0]  dqm;
	} sdc_pins_t;

	// One read word travelling to the output stage with its mask.
	typedef struct packed {
		logic [DQ_W-1:0]  data;
		logic [DQM_W-1:0] mask;
	} sdc_rd_word_t;

	localparam int RDW_W = DQ_W + DQM_W;

	// Column of beat cnt in a burst, linear or interleaved.
	function automatic logic [COL_W-1:0] sdc_burst_col(
		input logic [COL_W-1:0] start,
		input logic [COL_W-1:0] cnt,
		input logic [2:0]       bl,
		input logic             ilv
	);
		logic [COL_W-1:0] wrap;
		logic [COL_W-1:0] lin;
		wrap = (bl == BL_FULL) ? 8'hFF : 8'((9'h1 << bl) - 9'h1);
		lin  = ilv ? (start ^ cnt) : 8'(start + cnt);
		return (start & ~wrap) | (lin & wrap);
	endfunction : sdc_burst_col

	// True when beat cnt is the last beat of the burst.
	function automatic logic sdc_burst_last(
		input logic [COL_W-1:0] cnt,
		input logic [2:0]       bl
	);
		logic [COL_W-1:0] top;
		top = (bl == BL_FULL) ? 8'hFF : 8'((9'h1 << bl) - 9'h1);
		return cnt == top;
	endfunction : sdc_burst_last

endpackage : sdc_pkg

/* File: test/sdc_core_monitor.sv */
// Checker of the command interface core, bound to its ports.
`timescale 1ns/1ps
`default_nettype none
module sdc_core_monitor
	import sdc_pkg::*;
(
	// Clock and reset.
	input wire logic              sys_clk_in,
	input wire logic              rst_b_in,
	// Command pins.
	input wire logic              cke_in,
	input wire logic              cs_b_in,
	input wire logic              ras_b_in,
	input wire logic              cas_b_in,
	input wire logic              we_b_in,
	input wire logic              bank_sel_hi_in,
	input wire logic              bank_sel_lo_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DQM_W-1:0]  dqm_in,
	// Data and status pins.
	input wire logic [DQ_W-1:0]   dq_in,
	input wire logic [DQ_W-1:0]   dq_out,
	input wire logic              dq_oe_out,
	input wire logic [BANK_N-1:0] bank_open_out,
	input wire logic [1:0]        pwr_state_out,
	input wire logic [ADDR_W-1:0] refresh_row_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	// Decoded command, target bank and the cycles on which commands act.
	logic            cke_q;
	logic            cl3_q;
	wire logic [3:0] cmd   = {cs_b_in, ras_b_in, cas_b_in, we_b_in};
	wire logic [1:0] bank  = {bank_sel_hi_in, bank_sel_lo_in};
	wire logic       go    = cke_in && cke_q && pwr_state_out == PWR_RUN;
	wire logic       calm  = cke_in && cs_b_in;
	wire logic       idle  = bank_open_out == '0 && !dq_oe_out;
	wire logic       rd_go = go && cmd == CMD_RD && bank_open_out[bank];

	// Tracks the previous clock enable and the programmed read latency.
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cke_q <= 1'b1;
			cl3_q <= 1'b0;
		end else begin
			cke_q <= cke_in;
			if (go && cmd == CMD_MRS && bank_open_out == '0)
				cl3_q <= addr_in[6:4] == CL_3;
		end
	end

	// Undisturbed read with the latency of two and of three cycles.
	sequence s_cl2_read;
		(rd_go && !cl3_q) ##1 (calm && dqm_in == 2'h0) ##1 calm;
	endsequence
	sequence s_cl3_read;
		(rd_go && cl3_q) ##1 calm ##1 (calm && dqm_in == 2'h0) ##1 calm;
	endsequence

	a_cs_masks_cmd: assert property (
		cs_b_in |=> (bank_open_out & ~$past(bank_open_out)) == '0)
		else $error("bank opened on a deselected cycle");
	a_act_opens_bank: assert property (
		go && cmd == CMD_ACT |=> bank_open_out[$past(bank)])
		else $error("row open did not open the selected bank");
	a_pre_all_close: assert property (
		go && cmd == CMD_PRE && addr_in[AP_BIT] |=> bank_open_out == '0)
		else $error("precharge all left a bank open");
	a_pre_one_close: assert property (
		go && cmd == CMD_PRE && !addr_in[AP_BIT]
		|=> !bank_open_out[$past(bank)])
		else $error("bank precharge left its bank open");
	a_cl2_first_data: assert property (
		s_cl2_read |=> dq_oe_out)
		else $error("no read data two cycles after the read");
	a_cl3_first_data: assert property (
		s_cl3_read |=> dq_oe_out)
		else $error("no read data three cycles after the read");
	a_susp_entry: assert property (
		pwr_state_out == PWR_RUN && cke_q && !cke_in && cs_b_in
		&& bank_open_out != '0 |=> pwr_state_out == PWR_SUSP)
		else $error("clock enable low did not suspend");
	a_idle_pdown: assert property (
		pwr_state_out == PWR_RUN && cke_q && !cke_in && cs_b_in && idle
		|=> pwr_state_out == PWR_DOWN)
		else $error("clock enable low with idle banks not power down");
	a_susp_frozen: assert property (
		pwr_state_out == PWR_SUSP && !cke_in
		|=> $stable(dq_out) && $stable(dq_oe_out))
		else $error("data output moved while suspended");
	a_ref_step: assert property (
		go && cmd == CMD_REF && idle
		|=> refresh_row_out == $past(refresh_row_out) + 12'h001)
		else $error("auto refresh did not advance the row");
endmodule : sdc_core_monitor

bind sdc_core sdc_core_monitor u_mon (
	.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .cke_in(cke_in),
	.cs_b_in(cs_b_in), .ras_b_in(ras_b_in), .cas_b_in(cas_b_in),
	.we_b_in(we_b_in), .bank_sel_hi_in(bank_sel_hi_in),
	.bank_sel_lo_in(bank_sel_lo_in), .addr_in(addr_in), .dqm_in(dqm_in),
	.dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
	.bank_open_out(bank_open_out), .pwr_state_out(pwr_state_out),
	.refresh_row_out(refresh_row_out)
);
`default_nettype wire

/* File: test/sdc_core_tb.sv */
// Self-checking testbench of the command interface core.
`timescale 1ns/1ps
`default_nettype none
module sdc_core_tb
	import sdc_pkg::*;
();
	logic              sys_clk;
	logic              rst_b;
	logic              cke;
	sdc_pins_t         pins;
	logic [DQ_W-1:0]   dq_wr;
	logic [DQ_W-1:0]   dq_rd;
	logic              dq_oe;
	logic [BANK_N-1:0] bank_open;
	logic [1:0]        pwr_state;
	logic [ADDR_W-1:0] refresh_row;
	int                bad_count;
	int                checked;

	// Clock of 100 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Device under test and the controller in front of it.
	sdc_core u_dut (
		.sys_clk_in(sys_clk), .rst_b_in(rst_b), .cke_in(cke),
		.cs_b_in(pins.cs_b), .ras_b_in(pins.ras_b), .cas_b_in(pins.cas_b),
		.we_b_in(pins.we_b), .bank_sel_hi_in(pins.bank[1]),
		.bank_sel_lo_in(pins.bank[0]), .addr_in(pins.addr),
		.dqm_in(pins.dqm), .dq_in(dq_wr), .dq_out(dq_rd), .dq_oe_out(dq_oe),
		.bank_open_out(bank_open), .pwr_state_out(pwr_state),
		.refresh_row_out(refresh_row)
	);
	sdc_ctrl_model u_ctrl (
		.sys_clk_in(sys_clk), .cke_out(cke), .pins_out(pins), .dq_out(dq_wr)
	);

	// Compares one value and counts the outcome.
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	// Waits a bounded time for a power state; a hang ends the run.
	task automatic wait_pwr(input logic [1:0] exp);
		int n;
		n = 0;
		while (pwr_state !== exp && n < 20) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (pwr_state !== exp) begin
			bad_count++;
			stop_test();
		end
	endtask : wait_pwr

	// Outputs right after reset.
	task automatic t_reset();
		check("reset drive", {15'h0, dq_oe}, 16'h0000);
		check("reset banks", {12'h0, bank_open}, 16'h0000);
		check("reset power", {14'h0, pwr_state}, 16'h0000);
		check("reset row", {4'h0, refresh_row}, 16'h0000);
	endtask : t_reset

	// Deselected attempt, each bank opened, one closed, then all.
	task automatic t_banks();
		logic [3:0] exp;
		exp = 4'h0;
		u_ctrl.issue(sdc_cmd_t'(4'hB), 2'h3, 12'h000);
		check("deselected", {12'h0, bank_open}, 16'h0000);
		for (int b = 0; b < 4; b++) begin
			u_ctrl.issue(CMD_ACT, 2'(b), 12'hFFF);
			exp[b] = 1'b1;
			check("bank open", {12'h0, bank_open}, {12'h0, exp});
		end
		u_ctrl.issue(CMD_PRE, 2'h2, 12'hBFF);
		check("one closed", {12'h0, bank_open}, 16'h000B);
		u_ctrl.issue(CMD_PRE, 2'h0, 12'h400);
		check("all closed", {12'h0, bank_open}, 16'h0000);
	endtask : t_banks

	// Two-word burst written and read back at the chosen latency.
	task automatic t_burst(input logic cl3, input logic ap);
		u_ctrl.issue(CMD_PRE, 2'h0, 12'h400);
		u_ctrl.issue(CMD_MRS, 2'h0, cl3 ? 12'h031 : 12'h001);
		u_ctrl.issue(CMD_ACT, 2'h1, 12'hABC);
		u_ctrl.write2(2'h1, 8'h06, 16'h1234, 16'hBEEF);
		u_ctrl.issue(CMD_RD, 2'h1, {1'b0, ap, 10'h006});
		repeat (cl3 ? 3 : 2) @(posedge sys_clk);
		#1;
		check("first beat", dq_rd, 16'h1234);
		check("drive on", {15'h0, dq_oe}, 16'h0001);
		@(posedge sys_clk);
		#1;
		check("second beat", dq_rd, 16'hBEEF);
		@(posedge sys_clk);
		#1;
		check("drive off", {15'h0, dq_oe}, 16'h0000);
		repeat (2) @(posedge sys_clk);
		#1;
		check("row kept", {12'h0, bank_open}, ap ? 16'h0 : 16'h2);
	endtask : t_burst

	// Interleaved four-beat read, a stopped read and a suspended read.
	task automatic t_order();
		u_ctrl.issue(CMD_MRS, 2'h0, 12'h001);
		u_ctrl.issue(CMD_ACT, 2'h2, 12'h055);
		u_ctrl.write2(2'h2, 8'h04, 16'hA0A0, 16'hB1B1);
		u_ctrl.write2(2'h2, 8'h06, 16'hC2C2, 16'hD3D3);
		u_ctrl.issue(CMD_PRE, 2'h0, 12'h400);
		u_ctrl.issue(CMD_MRS, 2'h0, 12'h02A);
		u_ctrl.issue(CMD_ACT, 2'h2, 12'h055);
		u_ctrl.issue(CMD_RD, 2'h2, 12'h005);
		repeat (2) @(posedge sys_clk);
		#1;
		check("order beat 0", dq_rd, 16'hB1B1);
		@(posedge sys_clk);
		#1;
		check("order beat 1", dq_rd, 16'hA0A0);
		@(posedge sys_clk);
		#1;
		check("order beat 2", dq_rd, 16'hD3D3);
		@(posedge sys_clk);
		#1;
		check("order beat 3", dq_rd, 16'hC2C2);
		@(posedge sys_clk);
		#1;
		check("order end", {15'h0, dq_oe}, 16'h0000);
		u_ctrl.issue(CMD_RD, 2'h2, 12'h005);
		u_ctrl.issue(CMD_BST, 2'h0, 12'h000);
		@(posedge sys_clk);
		#1;
		check("stop beat 1", dq_rd, 16'hA0A0);
		@(posedge sys_clk);
		#1;
		check("stopped", {15'h0, dq_oe}, 16'h0000);
		u_ctrl.issue(CMD_RD, 2'h2, 12'h005);
		u_ctrl.set_cke(1'b0);
		repeat (3) @(posedge sys_clk);
		#1;
		check("frozen beat", dq_rd, 16'hB1B1);
		u_ctrl.set_cke(1'b1);
		repeat (2) @(posedge sys_clk);
		#1;
		check("resumed beat", dq_rd, 16'hA0A0);
		@(posedge sys_clk);
		#1;
		check("next beat", dq_rd, 16'hD3D3);
		repeat (2) @(posedge sys_clk);
		#1;
		check("suspend end", {15'h0, dq_oe}, 16'h0000);
		u_ctrl.issue(CMD_PRE, 2'h0, 12'h400);
	endtask : t_order

	// Auto refresh, clock suspend with a row open, then power down.
	task automatic t_power();
		u_ctrl.issue(CMD_REF, 2'h0, 12'h000);
		check("refresh row", {4'h0, refresh_row}, 16'h0001);
		u_ctrl.issue(CMD_ACT, 2'h1, 12'h123);
		u_ctrl.set_cke(1'b0);
		@(posedge sys_clk);
		#1;
		check("suspend", {14'h0, pwr_state}, 16'h0001);
		repeat (3) @(posedge sys_clk);
		#1;
		check("held row", {12'h0, bank_open}, 16'h0002);
		u_ctrl.set_cke(1'b1);
		wait_pwr(PWR_RUN);
		u_ctrl.issue(CMD_PRE, 2'h1, 12'h000);
		u_ctrl.set_cke(1'b0);
		@(posedge sys_clk);
		#1;
		check("power down", {14'h0, pwr_state}, 16'h0003);
		u_ctrl.set_cke(1'b1);
		wait_pwr(PWR_RUN);
		// Refresh with clock enable low enters self refresh.
		fork
			u_ctrl.set_cke(1'b0);
			u_ctrl.issue(CMD_REF, 2'h0, 12'h000);
		join
		check("self refresh", {14'h0, pwr_state}, 16'h0002);
		repeat (SELF_REF_INT) @(posedge sys_clk);
		#1;
		check("self row", {4'h0, refresh_row}, 16'h0002);
		u_ctrl.set_cke(1'b1);
		wait_pwr(PWR_RUN);
	endtask : t_power

	// Reset for 20 cycles, then the scenarios in turn.
	initial begin
		bad_count = 0;
		checked = 0;
		rst_b = 1'b0;
		repeat (20) @(negedge sys_clk);
		rst_b = 1'b1;
		t_reset();
		t_banks();
		t_burst(1'b0, 1'b0);
		t_burst(1'b1, 1'b1);
		t_order();
		t_power();
		stop_test();
	end
endmodule : sdc_core_tb
`default_nettype wire

/* File: test/sdc_ctrl_model.sv */
// Behavioural memory controller that drives the command and data pins.
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model
	import sdc_pkg::*;
(
	// Clock.
	input  wire logic           sys_clk_in,
	// Command and data pins.
	output var logic            cke_out,
	output var sdc_pins_t       pins_out,
	output var logic [DQ_W-1:0] dq_out
);
	// Pins start deselected with the clock running.
	initial begin
		cke_out = 1'b1;
		pins_out = '1;
		pins_out.dqm = 2'h0;
		dq_out = 16'h0000;
	end

	// One command for one edge; the address is scrambled afterwards.
	task automatic issue(input sdc_cmd_t c, input logic [1:0] b,
		input logic [ADDR_W-1:0] a);
		@(negedge sys_clk_in);
		{pins_out.cs_b, pins_out.ras_b, pins_out.cas_b, pins_out.we_b} = c;
		pins_out.bank = b;
		pins_out.addr = a;
		@(negedge sys_clk_in);
		pins_out.cs_b = 1'b1;
		pins_out.addr = ~a;
	endtask : issue

	// Two-beat write; the data lines carry junk once the beats are taken.
	task automatic write2(input logic [1:0] b, input logic [7:0] col,
		input logic [DQ_W-1:0] w0, input logic [DQ_W-1:0] w1);
		fork
			issue(CMD_WR, b, {4'h0, col});
			begin
				@(negedge sys_clk_in);
				dq_out = w0;
				@(negedge sys_clk_in);
				dq_out = w1;
			end
		join
		@(negedge sys_clk_in);
		dq_out = ~w1;
	endtask : write2

	// Changes the clock enable off the sampling edge.
	task automatic set_cke(input logic v);
		@(negedge sys_clk_in);
		cke_out = v;
	endtask : set_cke
endmodule : sdc_ctrl_model
`default_nettype wire
